/* File: verilog/sysctl_pkg.sv */
// Constants, encodings and types shared by the sleep and watchdog control block.
// Assumes one system clock, mclk, which is also the system clock of the core.
package sysctl_pkg;

  // I/O register addresses and field positions.
  localparam logic [7:0] ADDR_SELECT     = 8'hF0;
  localparam logic [7:0] ADDR_COMMAND    = 8'hF1;
  localparam int         DOG_EN_BIT      = 7;
  localparam int         PERIOD_HI       = 6;
  localparam int         PERIOD_LO       = 5;
  localparam int         MODE_HI         = 4;
  localparam int         MODE_LO         = 3;

  // Command bytes written to the command register.
  localparam logic [7:0] CMD_DOG_OFF     = 8'hB1;
  localparam logic [7:0] CMD_DOG_CLEAR   = 8'h4E;
  localparam logic [7:0] CMD_MODE_COMMIT = 8'hDB;

  typedef enum logic [1:0] {
    MODE_IDLE1 = 2'h0,
    MODE_IDLE2 = 2'h1,
    MODE_STOP  = 2'h2,
    MODE_RUN   = 2'h3
  } sleep_mode_t;

  typedef enum logic [2:0] {
    ST_AWAKE  = 3'b001,
    ST_ASLEEP = 3'b010,
    ST_NOP    = 3'b100
  } halt_state_t;

  // Reset values.
  localparam logic        RST_DOG_EN = 1'b1;
  localparam logic [1:0]  RST_PERIOD = 2'h3;
  localparam sleep_mode_t RST_MODE   = MODE_RUN;

  // Unit run-enable positions.
  localparam int UNIT_CLOCK_GEN = 0;
  localparam int UNIT_CPU       = 1;
  localparam int UNIT_TIMER     = 2;
  localparam int UNIT_SERPAR    = 3;
  localparam int UNIT_DOG       = 4;
  localparam int UNIT_CLOCK_OUT = 5;
  localparam int UNIT_W         = 6;

  // Timing.
  localparam int MCLK_PERIOD_NS         = 10;
  localparam int SYSTEM_CLOCK_PERIOD_NS = 10;
  localparam int DOG_PULSE_SYSCLK       = 5;
  localparam int DOG_PULSE_CYC =
    (DOG_PULSE_SYSCLK * SYSTEM_CLOCK_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int DOG_CNT_W    = 24;
  localparam int DOG_PERIOD0  = 65536;
  localparam int DOG_PERIOD1  = 262144;
  localparam int DOG_PERIOD2  = 1048576;
  localparam int DOG_PERIOD3  = 4194304;

endpackage : sysctl_pkg

/* File: verilog/dog_if.sv */
// Carrier between the control top and its watchdog counter.
// Assumes both ends sit on mclk.
interface dog_if;
  logic       run;
  logic       tick;
  logic       clear;
  logic [1:0] periodSel;
  logic       expired;

  modport ctl (output run, output tick, output clear, output periodSel, input expired);
  modport ctr (input run, input tick, input clear, input periodSel, output expired);
endinterface : dog_if

/* File: verilog/dog_counter.sv */
// Watchdog period counter: counts enabled cycles and pulses on reaching the period.
// Assumes the control top drives run, tick, clear and the period select on mclk.
module dog_counter #(
  parameter int P0 = sysctl_pkg::DOG_PERIOD0,
  parameter int P1 = sysctl_pkg::DOG_PERIOD1,
  parameter int P2 = sysctl_pkg::DOG_PERIOD2,
  parameter int P3 = sysctl_pkg::DOG_PERIOD3
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Control side
  dog_if.ctr        dog
);
  localparam int W = sysctl_pkg::DOG_CNT_W;

  if (P0 < 2 || P1 < 2 || P2 < 2 || P3 < 2 || P0 >= 2**W || P1 >= 2**W || P2 >= 2**W
      || P3 >= 2**W)
  begin : g_check
    $error("dog_counter: period out of range");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         expired;
  } ctr_state_t;

  ctr_state_t s_q;
  ctr_state_t s_d;
  logic [W-1:0] limit;

  always_comb
  begin
    case (dog.periodSel)
      2'h0:    limit = W'(P0 - 1);
      2'h1:    limit = W'(P1 - 1);
      2'h2:    limit = W'(P2 - 1);
      default: limit = W'(P3 - 1);
    endcase
    s_d = s_q;
    s_d.expired = 1'b0;
    // A clear restarts from zero and blocks the expiry pulse of the next cycle.
    if (dog.clear || !dog.run)
    begin
      s_d.cnt = '0;
    end
    else if (dog.tick)
    begin
      if (s_q.cnt == limit)
      begin
        s_d.cnt = '0;
        s_d.expired = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign dog.expired = s_q.expired;

  a_clear_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    dog.clear |=> (s_q.cnt == '0) && !s_q.expired)
    else $error("watchdog count not restarted by clear");
endmodule : dog_counter

/* File: verilog/watchdog_and_halt_mode_control.sv */
// Sleep mode selection and watchdog for a small processor system.
// Assumes the core drives I/O strobes and halt pulses on mclk; the request pins are asynchronous.
// How it works
// - On halt, enter the committed sleep mode from bits 4:3 of F0.
// - Reset leaves the committed mode at Run.
// - Nonmaskable request, maskable request or reset ends the asleep state; the no-op halt cycle returns to sleep unless reset.
// - Maskable request taken only when enabled; nonmaskable starts handling except in the no-op halt cycle, which drops its edge.
// - Masked request while asleep: leave, run halt as no-op, sleep again.
// - New mode at F0 takes effect only with the commit byte at F1.
// - Idle-1 clock only; Idle-2 adds timer and clock out; Stop none; Run all.
// - Bit 7 of F0 enables the watchdog; bits 6:5 pick its period.
// - Watchdog stops only after enable cleared and then B1 written to F1.
// - Writing 4E to F1 restarts the watchdog count from zero.
// - An enabled watchdog not cleared in time drives its output low.
// - Toward the reset pin the low pulse lasts five system clocks.
// - Otherwise the output stays low until cleared or reset.
module watchdog_and_halt_mode_control #(
  parameter int DOG_CNT0 = sysctl_pkg::DOG_PERIOD0,
  parameter int DOG_CNT1 = sysctl_pkg::DOG_PERIOD1,
  parameter int DOG_CNT2 = sysctl_pkg::DOG_PERIOD2,
  parameter int DOG_CNT3 = sysctl_pkg::DOG_PERIOD3
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  // Core I/O access
  input  wire logic                          ioWrite,
  input  wire logic                          ioRead,
  input  wire logic [7:0]                    ioAddr,
  input  wire logic [7:0]                    ioWdata,
  output logic      [7:0]                    ioRdata,
  // Core status and request pins
  input  wire logic                          haltExec,
  input  wire logic                          irq_enabled_state,
  input  wire logic                          nmiReq_n,
  input  wire logic                          intReq_n,
  input  wire logic                          pulseToReset,
  // Sleep control outputs
  output logic                               asleep,
  output logic                               nmiTake,
  output logic                               intTake,
  output logic                               haltNop,
  output logic [sysctl_pkg::UNIT_W-1:0]      unitRun,
  // Watchdog pin
  output logic                               dog_timeout_n
);
  ////////////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic                           dogEn;
    logic [1:0]                     period;
    logic [1:0]                     pendMode;
    sysctl_pkg::sleep_mode_t        mode;
    logic                           dogRun;
    sysctl_pkg::halt_state_t        st;
    logic [2:0]                     nmiSync;
    logic [1:0]                     intSync;
    logic [1:0]                     modeSync;
    logic                           latchLow;
    logic [3:0]                     pulseCnt;
    logic [7:0]                     rdata;
    logic [sysctl_pkg::UNIT_W-1:0]  units;
    logic                           nmiTake;
    logic                           intTake;
    logic                           haltNop;
  } state_t;

  state_t s_q;
  state_t s_d;
  dog_if  dog ();

  logic wrSel;
  logic wrCmd;
  logic nmiEdge;
  logic intReq;

  function automatic logic [sysctl_pkg::UNIT_W-1:0] unitsFor(
    input sysctl_pkg::halt_state_t st,
    input sysctl_pkg::sleep_mode_t m);
    logic [sysctl_pkg::UNIT_W-1:0] u;
    u = '0;
    if (st == sysctl_pkg::ST_AWAKE || m == sysctl_pkg::MODE_RUN)
      u = '1;
    else if (m == sysctl_pkg::MODE_IDLE1)
      u[sysctl_pkg::UNIT_CLOCK_GEN] = 1'b1;
    else if (m == sysctl_pkg::MODE_IDLE2)
    begin
      u[sysctl_pkg::UNIT_CLOCK_GEN] = 1'b1;
      u[sysctl_pkg::UNIT_TIMER]     = 1'b1;
      u[sysctl_pkg::UNIT_CLOCK_OUT] = 1'b1;
    end
    return u;
  endfunction : unitsFor

  assign wrSel   = ioWrite && (ioAddr == sysctl_pkg::ADDR_SELECT);
  assign wrCmd   = ioWrite && (ioAddr == sysctl_pkg::ADDR_COMMAND);
  assign nmiEdge = s_q.nmiSync[1] && !s_q.nmiSync[2];
  assign intReq  = s_q.intSync[1];

  ////////////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    s_d.nmiSync  = {s_q.nmiSync[1], s_q.nmiSync[0], !nmiReq_n};
    s_d.intSync  = {s_q.intSync[0], !intReq_n};
    s_d.modeSync = {s_q.modeSync[0], pulseToReset};
    s_d.nmiTake  = 1'b0;
    s_d.intTake  = 1'b0;
    s_d.haltNop  = 1'b0;
    s_d.rdata    = 8'h00;
    if (ioRead && ioAddr == sysctl_pkg::ADDR_SELECT)
      s_d.rdata = {s_q.dogEn, s_q.period, s_q.pendMode, 3'h0};
    if (wrSel)
    begin
      s_d.dogEn    = ioWdata[sysctl_pkg::DOG_EN_BIT];
      s_d.period   = ioWdata[sysctl_pkg::PERIOD_HI:sysctl_pkg::PERIOD_LO];
      s_d.pendMode = ioWdata[sysctl_pkg::MODE_HI:sysctl_pkg::MODE_LO];
      if (ioWdata[sysctl_pkg::DOG_EN_BIT])
        s_d.dogRun = 1'b1;
    end
    if (wrCmd && ioWdata == sysctl_pkg::CMD_MODE_COMMIT)
      s_d.mode = sysctl_pkg::sleep_mode_t'(s_q.pendMode);
    // Two steps guard against a runaway program silencing the watchdog.
    if (wrCmd && ioWdata == sysctl_pkg::CMD_DOG_OFF && !s_q.dogEn)
      s_d.dogRun = 1'b0;

    case (s_q.st)
      sysctl_pkg::ST_AWAKE:
      begin
        if (nmiEdge)
          s_d.nmiTake = 1'b1;
        else if (intReq && irq_enabled_state)
          s_d.intTake = 1'b1;
        else if (haltExec)
          s_d.st = sysctl_pkg::ST_ASLEEP;
      end
      sysctl_pkg::ST_ASLEEP:
      begin
        if (nmiEdge)
        begin
          s_d.nmiTake = 1'b1;
          s_d.st      = sysctl_pkg::ST_AWAKE;
        end
        else if (intReq && irq_enabled_state)
        begin
          s_d.intTake = 1'b1;
          s_d.st      = sysctl_pkg::ST_AWAKE;
        end
        else if (intReq)
        begin
          s_d.haltNop = 1'b1;
          s_d.st      = sysctl_pkg::ST_NOP;
        end
      end
      sysctl_pkg::ST_NOP:
        s_d.st = sysctl_pkg::ST_ASLEEP;
      default:
        s_d.st = sysctl_pkg::ST_AWAKE;
    endcase
    s_d.units = unitsFor(s_d.st, s_d.mode);

    // Expiry wins over a clear in the same cycle; the counter only suppresses expiry in the cycle after a clear.
    if (dog.expired && s_q.modeSync[1])
      s_d.pulseCnt = 4'(sysctl_pkg::DOG_PULSE_CYC);
    else if (s_q.pulseCnt != 4'h0)
      s_d.pulseCnt = s_q.pulseCnt - 4'h1;
    if (dog.expired && !s_q.modeSync[1])
      s_d.latchLow = 1'b1;
    else if (wrCmd && ioWdata == sysctl_pkg::CMD_DOG_CLEAR)
      s_d.latchLow = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s_q          <= '0;
      s_q.dogEn    <= sysctl_pkg::RST_DOG_EN;
      s_q.dogRun   <= sysctl_pkg::RST_DOG_EN;
      s_q.period   <= sysctl_pkg::RST_PERIOD;
      s_q.pendMode <= sysctl_pkg::RST_MODE;
      s_q.mode     <= sysctl_pkg::RST_MODE;
      s_q.st       <= sysctl_pkg::ST_AWAKE;
      s_q.units    <= '1;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // The watchdog only counts while its unit is clocked.
  assign dog.run       = s_q.dogRun;
  assign dog.tick      = s_q.units[sysctl_pkg::UNIT_DOG];
  assign dog.clear     = wrCmd && ioWdata == sysctl_pkg::CMD_DOG_CLEAR;
  assign dog.periodSel = s_q.period;

  dog_counter #(
    .P0 (DOG_CNT0),
    .P1 (DOG_CNT1),
    .P2 (DOG_CNT2),
    .P3 (DOG_CNT3)
  ) dog_counter_inst (
    .mclk  (mclk),
    .rst_n (rst_n),
    .dog   (dog)
  );

  assign ioRdata       = s_q.rdata;
  assign asleep        = s_q.st != sysctl_pkg::ST_AWAKE;
  assign nmiTake       = s_q.nmiTake;
  assign intTake       = s_q.intTake;
  assign haltNop       = s_q.haltNop;
  assign unitRun       = s_q.units;
  assign dog_timeout_n = !(s_q.latchLow || s_q.pulseCnt != 4'h0);

  ////////////////////////////////////////////////////////////////////////////////////////
  sequence maskedWake;
    s_q.st == sysctl_pkg::ST_ASLEEP && !nmiEdge && intReq && !irq_enabled_state;
  endsequence

  sequence nopThenSleep;
    s_q.st == sysctl_pkg::ST_NOP && haltNop ##1 s_q.st == sysctl_pkg::ST_ASLEEP;
  endsequence

  a_halt_enter: assert property (@(posedge mclk) disable iff (!rst_n)
    s_q.st == sysctl_pkg::ST_AWAKE && haltExec && !nmiEdge && !(intReq && irq_enabled_state)
    |=> asleep && unitRun == unitsFor(sysctl_pkg::ST_ASLEEP, s_q.mode))
    else $error("halt did not enter the selected mode");
  a_reset_run: assert property (@(posedge mclk)
    !$past(rst_n) && rst_n |-> s_q.mode == sysctl_pkg::MODE_RUN)
    else $error("mode not Run after reset");
  a_nmi_wake: assert property (@(posedge mclk) disable iff (!rst_n)
    s_q.st == sysctl_pkg::ST_ASLEEP && nmiEdge |=> !asleep && nmiTake)
    else $error("nonmaskable request did not wake");
  a_int_masked: assert property (@(posedge mclk) disable iff (!rst_n)
    intTake |-> $past(irq_enabled_state) && $past(intReq))
    else $error("maskable request taken while disabled");
  a_nop_reenter: assert property (@(posedge mclk) disable iff (!rst_n)
    maskedWake |=> nopThenSleep)
    else $error("masked request did not re-enter sleep");
  a_commit_only: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(s_q.mode) |-> $past(wrCmd) && $past(ioWdata) == sysctl_pkg::CMD_MODE_COMMIT)
    else $error("mode changed without commit");
  a_idle1_units: assert property (@(posedge mclk) disable iff (!rst_n)
    asleep && s_q.mode == sysctl_pkg::MODE_IDLE1 |-> unitRun == 6'h01)
    else $error("Idle-1 unit enables wrong");
  a_dog_off: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(s_q.dogRun) |-> $past(wrCmd) && $past(ioWdata) == sysctl_pkg::CMD_DOG_OFF
    && !$past(s_q.dogEn))
    else $error("watchdog stopped without both steps");
  a_pulse_width: assert property (@(posedge mclk) disable iff (!rst_n)
    dog.expired && s_q.modeSync[1] |=> (!dog_timeout_n)[*5] ##1 dog_timeout_n)
    else $error("timeout pulse not five clocks");
  a_latched_low: assert property (@(posedge mclk) disable iff (!rst_n)
    s_q.latchLow && !dog.clear |=> !dog_timeout_n)
    else $error("latched timeout released without clear");
endmodule : watchdog_and_halt_mode_control

/* File: verif/core_model.sv */
// Behavioural model of the core: I/O cycles, halt pulses and request pins.
// Assumes the block samples on rising mclk; every change here lands on the falling edge.
module core_model (
  // Clock
  input  wire logic       mclk,
  // I/O cycles and halt
  output logic            ioWrite,
  output logic            ioRead,
  output logic [7:0]      ioAddr,
  output logic [7:0]      ioWdata,
  input  wire logic [7:0] ioRdata,
  output logic            haltExec,
  // Interrupt state and request pins
  output logic            irq_enabled_state,
  output logic            nmiReq_n,
  output logic            intReq_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    ioWrite = 1'h0;
    ioRead = 1'h0;
    ioAddr = 8'h00;
    ioWdata = 8'h00;
    haltExec = 1'h0;
    irq_enabled_state = 1'h0;
    nmiReq_n = 1'h1;
    intReq_n = 1'h1;
  end

  // Software runs from the internal oscillator, so any mode may be chosen.
  // Between cycles the released bus shows the inverse, so stale values never match.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    ioAddr = a;
    ioWdata = d;
    ioWrite = 1'h1;
    @(negedge mclk);
    ioWrite = 1'h0;
    ioAddr = ~a;
    ioWdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    ioAddr = a;
    ioRead = 1'h1;
    @(negedge mclk);
    d = ioRdata;
    ioRead = 1'h0;
    ioAddr = ~a;
  endtask : rd

  task automatic halt();
    @(negedge mclk);
    haltExec = 1'h1;
    @(negedge mclk);
    haltExec = 1'h0;
  endtask : halt

  task automatic pins(input logic nmiLvl, input logic intLvl, input logic enLvl);
    @(negedge mclk);
    nmiReq_n = nmiLvl;
    intReq_n = intLvl;
    irq_enabled_state = enLvl;
  endtask : pins
endmodule : core_model

/* File: verif/tb_watchdog_and_halt_mode_control.sv */
// Self-checking bench for the sleep mode and watchdog control block.
// Assumes the core model drives the I/O side; short watchdog periods keep the run brief.
module tb_watchdog_and_halt_mode_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk;
  logic        rst_n;
  logic        pulseToReset;
  logic        ioWrite;
  logic        ioRead;
  logic [7:0]  ioAddr;
  logic [7:0]  ioWdata;
  logic [7:0]  ioRdata;
  logic        haltExec;
  logic        irq_enabled_state;
  logic        nmiReq_n;
  logic        intReq_n;
  logic        asleep;
  logic        nmiTake;
  logic        intTake;
  logic        haltNop;
  logic [5:0]  unitRun;
  logic        dog_timeout_n;
  logic [7:0]  d;
  logic [7:0]  junk;
  logic [1:0]  prev;
  logic [31:0] seed;
  int          n;
  int          miscompares;
  int          num_checks;

  watchdog_and_halt_mode_control #(
    .DOG_CNT0(16),
    .DOG_CNT1(32),
    .DOG_CNT2(64),
    .DOG_CNT3(128)
  ) watchdog_and_halt_mode_control_inst (
    .mclk(mclk), .rst_n(rst_n), .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr),
    .ioWdata(ioWdata), .ioRdata(ioRdata), .haltExec(haltExec),
    .irq_enabled_state(irq_enabled_state), .nmiReq_n(nmiReq_n), .intReq_n(intReq_n),
    .pulseToReset(pulseToReset), .asleep(asleep), .nmiTake(nmiTake), .intTake(intTake),
    .haltNop(haltNop), .unitRun(unitRun), .dog_timeout_n(dog_timeout_n)
  );

  core_model core_model_inst (
    .mclk(mclk), .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr), .ioWdata(ioWdata),
    .ioRdata(ioRdata), .haltExec(haltExec), .irq_enabled_state(irq_enabled_state),
    .nmiReq_n(nmiReq_n), .intReq_n(intReq_n)
  );

  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [7:0] exp_run(input logic [1:0] m);
    case (m)
      sysctl_pkg::MODE_IDLE1: return 8'h01;
      sysctl_pkg::MODE_IDLE2: return 8'h25;
      sysctl_pkg::MODE_STOP:  return 8'h00;
      default:                return 8'h3F;
    endcase
  endfunction : exp_run

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Counts falling edges until the chosen output shows lvl; n stays -1 if it never does.
  task automatic wait_sig(input int sel, input logic lvl, input int lim);
    logic v;
    n = -1;
    for (int i = 0; i < lim && n < 0; i++)
    begin
      @(negedge mclk);
      case (sel)
        0: v = dog_timeout_n;
        1: v = nmiTake;
        2: v = intTake;
        default: v = haltNop;
      endcase
      if (v === lvl)
        n = i;
    end
  endtask : wait_sig

  task automatic wake();
    if (xs() & 32'h1)
    begin
      core_model_inst.pins(1'h0, 1'h1, 1'h0);
      wait_sig(1, 1'h1, 10);
    end
    else
    begin
      core_model_inst.pins(1'h1, 1'h0, 1'h1);
      wait_sig(2, 1'h1, 10);
    end
    check({7'h0, n >= 0}, 8'h01);
    check({7'h0, asleep}, 8'h00);
    core_model_inst.pins(1'h1, 1'h1, 1'h0);
  endtask : wake

  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    miscompares++;
    $display("Error at %0t: run did not finish in time", $time);
    tally_and_finish();
  end

  initial
  begin
    rst_n = 1'h0;
    pulseToReset = 1'h1;
    seed = 32'hBF72;
    miscompares = 0;
    num_checks = 0;
    repeat (20) @(negedge mclk);
    rst_n = 1'h1;
    @(negedge mclk);
    check({2'h0, unitRun}, 8'h3F);
    check({7'h0, dog_timeout_n}, 8'h01);
    core_model_inst.rd(sysctl_pkg::ADDR_SELECT, d);
    check(d, 8'hF8);
    @(negedge mclk);
    check(ioRdata, 8'h00);
    $display("Test reset done");
    // Enable with the shortest period, restart it and time the pulse toward reset.
    core_model_inst.wr(sysctl_pkg::ADDR_SELECT, 8'h80);
    core_model_inst.wr(sysctl_pkg::ADDR_COMMAND, sysctl_pkg::CMD_DOG_CLEAR);
    wait_sig(0, 1'h0, 14);
    check({7'h0, n < 0}, 8'h01);
    wait_sig(0, 1'h0, 8);
    check({7'h0, n >= 0}, 8'h01);
    wait_sig(0, 1'h1, 10);
    check(n[7:0], 8'h04);
    // The off command alone, with the enable still set, must be refused.
    core_model_inst.wr(sysctl_pkg::ADDR_COMMAND, sysctl_pkg::CMD_DOG_OFF);
    pulseToReset = 1'h0;
    wait_sig(0, 1'h0, 40);
    check({7'h0, n >= 0}, 8'h01);
    wait_sig(0, 1'h1, 20);
    check({7'h0, n < 0}, 8'h01);
    core_model_inst.wr(sysctl_pkg::ADDR_COMMAND, sysctl_pkg::CMD_DOG_CLEAR);
    wait_sig(0, 1'h1, 2);
    check({7'h0, n >= 0}, 8'h01);
    core_model_inst.wr(sysctl_pkg::ADDR_SELECT, 8'h00);
    core_model_inst.wr(sysctl_pkg::ADDR_COMMAND, sysctl_pkg::CMD_DOG_OFF);
    wait_sig(0, 1'h0, 300);
    check({7'h0, n < 0}, 8'h01);
    $display("Test watchdog done");
    // A new mode must wait for the commit byte; junk command bytes change nothing.
    prev = sysctl_pkg::MODE_RUN;
    for (int m = 0; m < 4; m++)
    begin
      core_model_inst.wr(sysctl_pkg::ADDR_SELECT, {3'h0, m[1:0], 3'h0});
      core_model_inst.rd(sysctl_pkg::ADDR_SELECT, d);
      check(d, {3'h0, m[1:0], 3'h0});
      core_model_inst.halt();
      check({2'h0, unitRun}, exp_run(prev));
      check({7'h0, asleep}, 8'h01);
      wake();
      junk = 8'(xs());
      if (junk == 8'hB1 || junk == 8'h4E || junk == 8'hDB)
        junk = 8'h00;
      core_model_inst.wr(sysctl_pkg::ADDR_COMMAND, junk);
      core_model_inst.wr(sysctl_pkg::ADDR_COMMAND, sysctl_pkg::CMD_MODE_COMMIT);
      core_model_inst.halt();
      check({2'h0, unitRun}, exp_run(m[1:0]));
      wake();
      prev = m[1:0];
    end
    $display("Test modes done");
    // A masked request keeps bouncing through the no-op halt until it is enabled.
    core_model_inst.halt();
    core_model_inst.pins(1'h1, 1'h0, 1'h0);
    wait_sig(3, 1'h1, 10);
    check({7'h0, n >= 0}, 8'h01);
    wait_sig(3, 1'h1, 10);
    check({7'h0, n >= 0}, 8'h01);
    core_model_inst.pins(1'h1, 1'h0, 1'h1);
    wait_sig(2, 1'h1, 10);
    check({7'h0, n >= 0}, 8'h01);
    check({7'h0, asleep}, 8'h00);
    core_model_inst.pins(1'h1, 1'h1, 1'h0);
    $display("Test masked request done");
    // Second period code with a latched output, then a reset in mid-run while asleep.
    core_model_inst.wr(sysctl_pkg::ADDR_SELECT, 8'hA8);
    core_model_inst.rd(sysctl_pkg::ADDR_SELECT, d);
    check(d, 8'hA8);
    core_model_inst.wr(sysctl_pkg::ADDR_COMMAND, sysctl_pkg::CMD_MODE_COMMIT);
    core_model_inst.wr(sysctl_pkg::ADDR_COMMAND, sysctl_pkg::CMD_DOG_CLEAR);
    wait_sig(0, 1'h0, 30);
    check({7'h0, n < 0}, 8'h01);
    wait_sig(0, 1'h0, 8);
    check({7'h0, n >= 0}, 8'h01);
    core_model_inst.halt();
    check({2'h0, unitRun}, 8'h25);
    rst_n = 1'h0;
    repeat (2) @(negedge mclk);
    rst_n = 1'h1;
    @(negedge mclk);
    check({7'h0, asleep}, 8'h00);
    check({7'h0, dog_timeout_n}, 8'h01);
    core_model_inst.halt();
    check({2'h0, unitRun}, 8'h3F);
    wake();
    $display("Test period and mid-run reset done");
    tally_and_finish();
  end
endmodule : tb_watchdog_and_halt_mode_control
